/* eas_pkg.sv */
// Shared constants and types for the status register map block
package eas_pkg;

  // ----------------------------------------
  // Register addresses
  // ----------------------------------------
  localparam logic [6:0] ADDR_NULL_LO = 7'h00;
  localparam logic [6:0] ADDR_STATUS = 7'h01;
  localparam logic [6:0] ADDR_CAL_CFG = 7'h12;
  localparam logic [6:0] ADDR_MUX_CFG = 7'h14;
  localparam logic [6:0] ADDR_ECG_CFG = 7'h15;
  localparam logic [6:0] ADDR_BEAT_CFG_A = 7'h1D;
  localparam logic [6:0] ADDR_BEAT_CFG_B = 7'h1E;
  localparam logic [6:0] ADDR_QUEUE_BURST = 7'h20;
  localparam logic [6:0] ADDR_QUEUE_SINGLE = 7'h21;
  localparam logic [6:0] ADDR_BEAT_INTERVAL = 7'h25;
  localparam logic [6:0] ADDR_NULL_HI = 7'h7F;

  // ----------------------------------------
  // Word layout and reset values
  // ----------------------------------------
  localparam int unsigned REG_W = 24;
  localparam int unsigned QUEUE_DEPTH = 32;
  localparam logic [23:0] CFG_RESET = 24'h000000;
  localparam int BIT_QTHR = 23;
  localparam int BIT_QOVF = 22;
  localparam int BIT_FAST = 21;
  localparam int BIT_DCLO = 20;
  localparam int BIT_LON = 11;
  localparam int BIT_BEAT = 10;
  localparam int BIT_SAMPLE_PULSE_FLAG = 9;
  localparam int BIT_UNLOCK = 8;
  localparam int BIT_DETAIL_LSB = 0;

  // ----------------------------------------
  // Serial frame edge counts
  // ----------------------------------------
  localparam logic [5:0] EDGE_ADDR = 6'h08;
  localparam logic [5:0] EDGE_POP = 6'h1E;
  localparam logic [5:0] EDGE_LAST = 6'h20;
  localparam logic [5:0] EDGE_WRAP = 6'h09;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_ADDR = 2'b01,
    PH_DATA = 2'b10
  } eas_phase_t;

  typedef struct packed {
    logic fast_recovery;
    logic dc_lead_off;
    logic pos_above_high;
    logic pos_below_low;
    logic neg_above_high;
    logic neg_below_low;
    logic leads_on;
    logic beat_event;
    logic sample_pulse;
    logic loop_unlock;
  } eas_cond_t;

  typedef struct packed {
    logic [23:0] calibration_config;
    logic [23:0] input_mux_config;
    logic [23:0] ecg_channel_config;
    logic [23:0] beat_detect_config_a;
    logic [23:0] beat_detect_config_b;
  } eas_cfg_t;

endpackage

/* eas_queue.sv */
// Sample queue with registered read data and registered flags
`timescale 1ns/1ps
module eas_queue #(
  parameter int unsigned W = 24,
  parameter int unsigned D = 32
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic flush_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [W-1:0] out_data_o,
  output logic [$clog2(D):0] level_o
);
  localparam int unsigned AW = $clog2(D);

  logic [W-1:0] mem_q [D];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW-1:0] rp_d;
  logic [AW:0] lvl_q;
  logic [AW:0] lvl_d;
  logic full_q;
  logic empty_q;
  logic [W-1:0] data_q;
  wire push = in_valid_i & ~full_q;
  wire pop = out_ready_i & ~empty_q;

  assign rp_d = flush_i ? '0 : (pop ? rp_q + 1'b1 : rp_q);

  always_comb begin
    lvl_d = lvl_q;
    if (flush_i) begin
      lvl_d = '0;
    end else if (push && !pop) begin
      lvl_d = lvl_q + 1'b1;
    end else if (pop && !push) begin
      lvl_d = lvl_q - 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (push) begin
      mem_q[wp_q] <= in_data_i;
    end
  end

  // Head word bypasses the array when written into an empty slot
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wp_q <= '0;
      rp_q <= '0;
      lvl_q <= '0;
      full_q <= 1'b0;
      empty_q <= 1'b1;
      data_q <= '0;
    end else begin
      wp_q <= flush_i ? '0 : (push ? wp_q + 1'b1 : wp_q);
      rp_q <= rp_d;
      lvl_q <= lvl_d;
      full_q <= (lvl_d == (AW+1)'(D));
      empty_q <= (lvl_d == '0);
      data_q <= (push && !flush_i && wp_q == rp_d) ? in_data_i : mem_q[rp_d];
    end
  end

  assign in_ready_o = ~full_q;
  assign out_valid_o = ~empty_q;
  assign out_data_o = data_q;
  assign level_o = lvl_q;
endmodule // eas_queue

/* eas_status_map.sv */
// Serial register map: null, status, configuration, sample queue and beat interval
`timescale 1ns/1ps
module eas_status_map #(
  parameter int unsigned QW = 24,
  parameter int unsigned QD = 32
) (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdi_i,
  output logic spi_sdo_o,
  output logic spi_sdo_oe_o,
  input wire logic smp_valid_i,
  input wire logic [QW-1:0] smp_data_i,
  output logic smp_ready_o,
  input wire eas_pkg::eas_cond_t cond_i,
  input wire logic [$clog2(QD)-1:0] queue_thresh_i,
  input wire logic queue_reset_i,
  input wire logic sync_i,
  input wire logic [23:0] beat_interval_i,
  input wire logic beat_interval_valid_i,
  output eas_pkg::eas_cfg_t cfg_o
);
  import eas_pkg::*;

  // ----------------------------------------
  // Pin synchronisers and edge detection
  // ----------------------------------------
  logic [2:0] sclk_q;
  logic [1:0] csb_q;
  logic [1:0] sdi_q;

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sclk_q <= 3'h0;
      csb_q <= 2'h3;
      sdi_q <= 2'h0;
    end else begin
      sclk_q <= {sclk_q[1:0], spi_sclk_i};
      csb_q <= {csb_q[0], spi_csb_n_i};
      sdi_q <= {sdi_q[0], spi_sdi_i};
    end
  end

  wire sel = ~csb_q[1];
  wire sdi_s = sdi_q[1];
  wire rise = sel & sclk_q[1] & ~sclk_q[2];
  wire fall = sel & ~sclk_q[1] & sclk_q[2];

  // ----------------------------------------
  // Frame state
  // ----------------------------------------
  eas_phase_t ph_q;
  eas_phase_t ph_d;
  logic [5:0] cnt_q;
  logic [5:0] cnt_d;
  logic [6:0] ash_q;
  logic [6:0] addr_q;
  logic rd_q;
  logic [23:0] wsh_q;
  logic [23:0] sh_q;
  logic sdo_q;
  logic sdo_oe_q;

  wire [7:0] aword = {ash_q, sdi_s};
  wire [6:0] a_now = aword[7:1];
  wire [23:0] wword = {wsh_q[22:0], sdi_s};
  wire burst_q = (addr_q == ADDR_QUEUE_BURST);
  wire queue_q = burst_q | (addr_q == ADDR_QUEUE_SINGLE);
  wire at_addr = rise & (cnt_d == EDGE_ADDR);
  wire at_last = rise & (ph_q == PH_DATA) & (cnt_d == EDGE_LAST);
  wire at_pop = rise & (ph_q == PH_DATA) & (cnt_d == EDGE_POP);

  always_comb begin
    ph_d = ph_q;
    cnt_d = cnt_q;
    case (ph_q)
      PH_IDLE: begin
        cnt_d = 6'h00;
        if (sel) begin
          ph_d = PH_ADDR;
        end
      end
      PH_ADDR: begin
        if (rise) begin
          cnt_d = cnt_q + 6'h01;
          if (cnt_d == EDGE_ADDR) begin
            ph_d = PH_DATA;
          end
        end
      end
      PH_DATA: begin
        if (rise) begin
          if (cnt_q == EDGE_LAST) begin
            cnt_d = (rd_q && burst_q) ? EDGE_WRAP : EDGE_LAST;
          end else begin
            cnt_d = cnt_q + 6'h01;
          end
        end
      end
      default: begin
        ph_d = PH_IDLE;
        cnt_d = 6'h00;
      end
    endcase
    if (!sel) begin
      ph_d = PH_IDLE;
      cnt_d = 6'h00;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ph_q <= PH_IDLE;
      cnt_q <= 6'h00;
    end else begin
      ph_q <= ph_d;
      cnt_q <= cnt_d;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      ash_q <= 7'h00;
      addr_q <= ADDR_NULL_LO;
      rd_q <= 1'b0;
      wsh_q <= 24'h000000;
    end else if (rise && ph_q == PH_ADDR) begin
      ash_q <= aword[6:0];
      if (at_addr) begin
        addr_q <= a_now;
        rd_q <= aword[0];
      end
    end else if (rise && ph_q == PH_DATA) begin
      wsh_q <= wword;
    end
  end

  // ----------------------------------------
  // Sample queue
  // ----------------------------------------
  logic q_valid;
  logic [QW-1:0] q_data;
  logic [$clog2(QD):0] q_level;
  wire q_pop = at_pop & rd_q & queue_q & q_valid;
  wire q_drop = smp_valid_i & ~smp_ready_o;

  eas_queue #(
    .W(QW),
    .D(QD)
  ) u_queue (
    .core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .flush_i(queue_reset_i | sync_i),
    .in_valid_i(smp_valid_i),
    .in_data_i(smp_data_i),
    .in_ready_o(smp_ready_o),
    .out_valid_o(q_valid),
    .out_ready_i(q_pop),
    .out_data_o(q_data),
    .level_o(q_level)
  );

  // ----------------------------------------
  // Status flags
  // ----------------------------------------
  logic qthr_q;
  logic qovf_q;
  logic [7:0] lat_q;
  logic [3:0] det_q;
  logic [23:0] beat_q;

  wire stat_clr = at_last & rd_q & (addr_q == ADDR_STATUS);
  wire [7:0] lat_set = {
    1'b0, 1'b0, cond_i.fast_recovery, cond_i.dc_lead_off,
    cond_i.leads_on, cond_i.beat_event, cond_i.sample_pulse, cond_i.loop_unlock
  };
  wire [3:0] det_set = {
    cond_i.pos_above_high, cond_i.pos_below_low,
    cond_i.neg_above_high, cond_i.neg_below_low
  };
  wire thr_hit = (q_level > {1'b0, queue_thresh_i});

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      lat_q <= 8'h00;
      det_q <= 4'h0;
      qovf_q <= 1'b0;
      qthr_q <= 1'b0;
    end else begin
      lat_q <= lat_set | (lat_q & {8{~stat_clr}});
      det_q <= det_set | (det_q & {4{~stat_clr}});
      qovf_q <= q_drop | (qovf_q & ~(queue_reset_i | sync_i));
      qthr_q <= thr_hit;
    end
  end

  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      beat_q <= 24'h000000;
    end else if (beat_interval_valid_i) begin
      beat_q <= beat_interval_i;
    end
  end

  logic [23:0] status_w;

  always_comb begin
    status_w = 24'h000000;
    status_w[BIT_QTHR] = qthr_q;
    status_w[BIT_QOVF] = qovf_q;
    status_w[BIT_FAST] = lat_q[5];
    status_w[BIT_DCLO] = lat_q[4];
    status_w[BIT_LON] = lat_q[3];
    status_w[BIT_BEAT] = lat_q[2];
    status_w[BIT_SAMPLE_PULSE_FLAG] = lat_q[1];
    status_w[BIT_UNLOCK] = lat_q[0];
    status_w[BIT_DETAIL_LSB +: 4] = det_q;
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  eas_cfg_t cfg_q;
  wire wr_go = at_last & ~rd_q;

  // Only the configuration addresses accept data; null and read-only ones drop it
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_q <= {5{CFG_RESET}};
    end else if (wr_go) begin
      case (addr_q)
        ADDR_CAL_CFG: cfg_q.calibration_config <= wword;
        ADDR_MUX_CFG: cfg_q.input_mux_config <= wword;
        ADDR_ECG_CFG: cfg_q.ecg_channel_config <= wword;
        ADDR_BEAT_CFG_A: cfg_q.beat_detect_config_a <= wword;
        ADDR_BEAT_CFG_B: cfg_q.beat_detect_config_b <= wword;
        default: cfg_q <= cfg_q;
      endcase
    end
  end

  assign cfg_o = cfg_q;

  // ----------------------------------------
  // Read data selection and serial output
  // ----------------------------------------
  logic [23:0] rd_word;
  wire [23:0] q_word = q_valid ? q_data : 24'h000000;

  always_comb begin
    case (a_now)
      ADDR_STATUS: rd_word = status_w;
      ADDR_CAL_CFG: rd_word = cfg_q.calibration_config;
      ADDR_MUX_CFG: rd_word = cfg_q.input_mux_config;
      ADDR_ECG_CFG: rd_word = cfg_q.ecg_channel_config;
      ADDR_BEAT_CFG_A: rd_word = cfg_q.beat_detect_config_a;
      ADDR_BEAT_CFG_B: rd_word = cfg_q.beat_detect_config_b;
      ADDR_QUEUE_BURST: rd_word = q_word;
      ADDR_QUEUE_SINGLE: rd_word = q_word;
      ADDR_BEAT_INTERVAL: rd_word = beat_q;
      default: rd_word = 24'h000000;
    endcase
  end

  wire load_first = at_addr & aword[0];
  // Next burst word must be in place before the falling edge that follows edge 32
  wire load_next = at_last & rd_q & burst_q;

  // Shifter drains MSB first on falling edges; single reads run out to zeros
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sh_q <= 24'h000000;
      sdo_q <= 1'b0;
      sdo_oe_q <= 1'b0;
    end else begin
      sdo_oe_q <= sel;
      if (!sel) begin
        sh_q <= 24'h000000;
        sdo_q <= 1'b0;
      end else if (load_first) begin
        sh_q <= rd_word;
      end else if (load_next) begin
        sh_q <= q_word;
      end else if (fall && ph_q == PH_DATA) begin
        sdo_q <= sh_q[23];
        sh_q <= {sh_q[22:0], 1'b0};
      end
    end
  end

  assign spi_sdo_o = sdo_q;
  assign spi_sdo_oe_o = sdo_oe_q;
endmodule // eas_status_map

/* eas_status_map_asserts.sv */
// Port-level checks for the serial register map
`timescale 1ns/1ps
module eas_status_map_asserts (
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic spi_csb_n_i,
  input wire logic spi_sclk_i,
  input wire logic spi_sdo_o,
  input wire logic spi_sdo_oe_o,
  input wire logic smp_ready_o,
  input wire logic queue_reset_i,
  input wire logic sync_i,
  input wire eas_pkg::eas_cfg_t cfg_o
);
  import eas_pkg::*;
  logic s1_q;
  logic s2_q;
  logic [5:0] edges_q;

  // Rising serial edges seen in the current frame
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      edges_q <= 6'h00;
    end else begin
      s1_q <= spi_sclk_i;
      s2_q <= s1_q;
      edges_q <= spi_csb_n_i ? 6'h00 : edges_q + {5'h00, s1_q & !s2_q};
    end
  end

  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!rst_n_i);

  a_header_quiet: assert property (!spi_csb_n_i && edges_q < 6'h07 |-> !spi_sdo_o)
    else $error("data out active during header");
  a_idle_low: assert property (spi_csb_n_i [*5] |-> !spi_sdo_o && !spi_sdo_oe_o)
    else $error("data out driven while deselected");
  a_oe_select: assert property (!spi_csb_n_i [*5] |-> spi_sdo_oe_o)
    else $error("data out enable missing in frame");
  a_shift_fall: assert property ($changed(spi_sdo_o) && !spi_csb_n_i |-> !spi_sclk_i)
    else $error("data out moved while serial clock high");
  a_cfg_commit: assert property ($changed(cfg_o) |-> !spi_csb_n_i && edges_q >= 6'h1F)
    else $error("config changed outside a write end");
  a_flush_ready: assert property (queue_reset_i |-> ##[1:3] smp_ready_o)
    else $error("queue reset left queue full");
  a_sync_ready: assert property (sync_i |=> ##[0:2] smp_ready_o)
    else $error("sync left queue full");
  a_full_hold: assert property (!smp_ready_o && spi_csb_n_i && !queue_reset_i && !sync_i
    && !$past(queue_reset_i) && !$past(sync_i) |=> !smp_ready_o)
    else $error("full queue drained without a read");

  c_write: cover property ($changed(cfg_o));
  c_full: cover property ($fell(smp_ready_o));
  c_burst: cover property (edges_q == 6'h38);
endmodule // eas_status_map_asserts

/* eas_host.sv */
// Host model issuing serial register frames
`timescale 1ns/1ps
module eas_host (
  output logic csb_n_o,
  output logic sclk_o,
  output logic sdi_o,
  input wire logic sdo_i
);
  logic [23:0] got[$];

  initial begin
    csb_n_o = 1'b1;
    sclk_o = 1'b0;
    sdi_o = 1'b0;
  end

  // Header, then nw words; sdi toggles once its bits are spent
  task automatic frame(input logic [6:0] a, input logic rd_en, input logic [23:0] wd,
                       input int nw);
    logic [31:0] sh;
    logic [23:0] w;
    sh = {a, rd_en, wd};
    w = 24'h000000;
    got.delete();
    csb_n_o = 1'b0;
    for (int i = 0; i < 8 + 24 * nw; i++) begin
      sdi_o = (i < 32) ? sh[31 - i] : ~sdi_o;
      #100;
      if (i > 7) w = {w[22:0], sdo_i};
      if (i > 7 && (i - 8) % 24 == 23) got.push_back(w);
      sclk_o = 1'b1;
      #100;
      sclk_o = 1'b0;
    end
    #100;
    csb_n_o = 1'b1;
    sdi_o = ~sdi_o;
    #200;
  endtask
endmodule // eas_host

/* ecg_afe_status_register_map_tb.sv */
// Self-checking bench for the serial register map
`timescale 1ns/1ps
module ecg_afe_status_register_map_tb;
  import eas_pkg::*;
  logic core_clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic csb_n, sclk, sdi, sdo, sdo_oe, smp_valid, smp_ready, qrst, sync_s, bvalid;
  logic [23:0] smp_data, bint, x;
  logic [4:0] thr;
  eas_cond_t cond;
  eas_cfg_t cfg;
  int fails = 0;
  int comparisons = 0;
  logic [31:0] lf = 32'h283D;
  logic [23:0] mq[$];
  logic [23:0] mcfg[5];
  logic [9:0] stk = 10'h000;
  logic ovf = 1'b0;
  logic [6:0] ca[5] = '{ADDR_CAL_CFG, ADDR_MUX_CFG, ADDR_ECG_CFG, ADDR_BEAT_CFG_A,
                        ADDR_BEAT_CFG_B};
  logic [6:0] na[7] = '{ADDR_NULL_LO, ADDR_NULL_HI, ADDR_STATUS, ADDR_QUEUE_BURST,
                        ADDR_QUEUE_SINGLE, ADDR_BEAT_INTERVAL, 7'h33};

  always #12.5 core_clk_i = ~core_clk_i;

  // Host sees an undriven data line as the inverse of the last bit
  wire sdo_seen = sdo_oe ? sdo : ~sdo;

  eas_host host (.csb_n_o(csb_n), .sclk_o(sclk), .sdi_o(sdi), .sdo_i(sdo_seen));

  eas_status_map uut (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i), .spi_csb_n_i(csb_n),
    .spi_sclk_i(sclk), .spi_sdi_i(sdi), .spi_sdo_o(sdo), .spi_sdo_oe_o(sdo_oe),
    .smp_valid_i(smp_valid), .smp_data_i(smp_data), .smp_ready_o(smp_ready),
    .cond_i(cond), .queue_thresh_i(thr), .queue_reset_i(qrst), .sync_i(sync_s),
    .beat_interval_i(bint), .beat_interval_valid_i(bvalid), .cfg_o(cfg));

  function automatic logic [23:0] rnd();
    lf = {lf[30:0], lf[31] ^ lf[21] ^ lf[1] ^ lf[0]};
    return lf[23:0];
  endfunction

  function automatic logic [23:0] pop();
    return (mq.size() > 0) ? mq.pop_front() : 24'h000000;
  endfunction

  function automatic logic [23:0] st();
    return {mq.size() > thr, ovf, stk[9:8], 8'h00, stk[3:0], 4'h0, stk[7:4]};
  endfunction

  task automatic chk(input logic [23:0] g, input logic [23:0] e);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, g, e);
    end
  endtask

  task automatic conclude();
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [23:0] d);
    @(negedge core_clk_i);
    host.frame(a, 1'b0, d, 1);
  endtask

  // Queue addresses pop the model; others expect v
  task automatic rd(input logic [6:0] a, input int n, input logic [23:0] v);
    @(negedge core_clk_i);
    host.frame(a, 1'b1, rnd(), n);
    for (int k = 0; k < n; k++) begin
      chk(host.got[k], (a == ADDR_QUEUE_BURST || a == ADDR_QUEUE_SINGLE) ? pop() : v);
    end
  endtask

  task automatic push(input int n);
    repeat (n) begin
      @(negedge core_clk_i);
      smp_data = rnd();
      smp_valid = 1'b1;
      if (mq.size() < QUEUE_DEPTH) mq.push_back(smp_data);
      else ovf = 1'b1;
      @(negedge core_clk_i);
      smp_valid = 1'b0;
    end
  endtask

  task automatic cfgchk();
    foreach (ca[i]) begin
      rd(ca[i], 1, mcfg[i]);
      chk(cfg[(4 - i) * 24 +: 24], mcfg[i]);
    end
  endtask

  // About 67 frames of 7 us each, with margin
  initial begin
    #1_000_000;
    fails++;
    conclude();
  end

  initial begin
    {smp_valid, qrst, sync_s, bvalid} = 4'h0;
    {smp_data, bint} = 48'h0;
    cond = '0;
    thr = 5'h02;
    repeat (10) @(negedge core_clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge core_clk_i);
    chk({22'h0, smp_ready, sdo_oe}, 24'h000002);
    foreach (ca[i]) begin
      mcfg[i] = rnd();
      wr(ca[i], mcfg[i]);
    end
    cfgchk();
    push(3);
    rd(ADDR_STATUS, 1, st());
    foreach (na[i]) wr(na[i], rnd());
    cfgchk();
    for (int i = 0; i < 3; i++) rd(na[(i == 1) ? 1 : i * 3], 1, 24'h000000);
    rd(ADDR_QUEUE_SINGLE, 1, 24'h0);
    rd(ADDR_STATUS, 1, st());
    rd(ADDR_QUEUE_BURST, 3, 24'h0);
    for (int b = 0; b < 10; b++) begin
      @(negedge core_clk_i);
      cond = eas_cond_t'(10'h001 << b);
      @(negedge core_clk_i);
      cond = '0;
      stk[b] = 1'b1;
      wr(ADDR_STATUS, 24'hFFFFFF);
      rd(ADDR_STATUS, 1, st());
      stk = 10'h000;
      rd(ADDR_STATUS, 1, st());
    end
    for (int k = 0; k < 2; k++) begin
      push(33);
      chk({23'h0, smp_ready}, 24'h000000);
      rd(ADDR_STATUS, 1, st());
      rd(ADDR_STATUS, 1, st());
      @(negedge core_clk_i);
      {sync_s, qrst} = (k == 0) ? 2'b01 : 2'b10;
      @(negedge core_clk_i);
      {sync_s, qrst} = 2'b00;
      mq.delete();
      ovf = 1'b0;
      rd(ADDR_STATUS, 1, st());
    end
    @(negedge core_clk_i);
    bint = rnd();
    bvalid = 1'b1;
    @(negedge core_clk_i);
    bvalid = 1'b0;
    x = bint;
    bint = rnd();
    wr(ADDR_BEAT_INTERVAL, rnd());
    rd(ADDR_BEAT_INTERVAL, 1, x);
    conclude();
  end
endmodule // ecg_afe_status_register_map_tb

bind eas_status_map eas_status_map_asserts u_chk (.core_clk_i(core_clk_i),
  .rst_n_i(rst_n_i), .spi_csb_n_i(spi_csb_n_i), .spi_sclk_i(spi_sclk_i),
  .spi_sdo_o(spi_sdo_o), .spi_sdo_oe_o(spi_sdo_oe_o), .smp_ready_o(smp_ready_o),
  .queue_reset_i(queue_reset_i), .sync_i(sync_i), .cfg_o(cfg_o));
